// [rtl/timer_core_regs.svh]
// register offsets, field positions, reset values and timing counts of the delay timer core
// ****************************************************************************
// Overview of operation
// R01: a start begins timing; reaching the set value switches the output per mode
// R02: reset input stops timing, zeroes elapsed time, forces the output off
// R03: gate active pauses accumulation; release resumes from the held value
// R04: counting intervals split by the gate add up toward the set value
// R05: start and reset still act while the gate is active
// R06: the source holds start and reset pulses at least 0.05 s
// R07: supply stays off at least 0.1 s for a power-off reset
// R08: one-shot mode gives one pulse per start, however long start stays
// R09: a set value below zero counts as zero; the output switches at once
// R10: lamp flash rate changes once elapsed reaches 90 percent of set value
// R11: eight modes on the full variant, five on the reduced-pin variant
// R12: voltage-input variant has start only; reset and gate do nothing
// R13: reduced-pin variant has no inputs; power-up acts as the start
// R14: transistor variant drives only the normally-open time-limit output
// R15: full scales 1.2, 3, 12, 30 units; the double variant doubles them
// R16: elapsed time is a count of timebase ticks compared to the scaled set
// ****************************************************************************
`ifndef TIMER_CORE_REGS_SVH
`define TIMER_CORE_REGS_SVH

// register byte addresses
`define TMR_ADDR_CTRL    4'h0
`define TMR_ADDR_SET     4'h4
`define TMR_ADDR_STATUS  4'h8
`define TMR_ADDR_ELAPSED 4'hC

// control register fields
`define CTRL_MODE   2:0
`define CTRL_RANGE  4:3
`define CTRL_DOUBLE 5
`define CTRL_VAR    7:6
`define CTRL_TRANS  8
`define CTRL_W      9
`define CTRL_RESET  9'h000
`define SET_RESET   16'h0000

// pin positions inside the synchronised pin vector
`define PIN_START 0
`define PIN_RESET 1
`define PIN_GATE  2

// full scales in ticks of 10 ms (hundredths of a unit)
`define FS_RANGE0 16'h0078
`define FS_RANGE1 16'h012C
`define FS_RANGE2 16'h04B0
`define FS_RANGE3 16'h0BB8

// near-end threshold as a ratio: elapsed * 10 >= set * 9
`define NEAR_NUM 20'h00009
`define NEAR_DEN 20'h0000A

// timebase
`define TMR_CLK_NS  40
`define TMR_TICK_NS 10000000
`define TMR_TICK_CYCLES (`TMR_TICK_NS / `TMR_CLK_NS)
`define SLOW_HALF_TICKS 7'h32
`define FAST_HALF_TICKS 7'h0A

`endif

// [rtl/timer_core_pkg.sv]
// types shared by the delay timer core modules
package timer_core_pkg;

  // operating modes: on-delay, flicker off/on start, signal on/off-delay,
  // signal off-delay, interval, on/off-delay second form, one-shot
  typedef enum logic [2:0] {
    MODE_A, MODE_B, MODE_B2, MODE_C, MODE_D, MODE_E, MODE_G, MODE_J
  } mode_t;

  // product variant: full inputs, voltage start only, reduced pins, spare
  typedef enum logic [1:0] {VAR_FULL, VAR_VOLT, VAR_REDUCED, VAR_SPARE} variant_t;

  // timing sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ON_DLY, ST_OFF_DLY, ST_HOLD} state_t;

endpackage

// [rtl/timer_link_if.sv]
// signals passed from the pin synchroniser and timebase to the timer core
`timescale 1ns/1ns
interface timer_link_if;
  logic       tick;
  logic       lamp_slow;
  logic       lamp_fast;
  logic [2:0] pins_sync;

  modport src_tb (output tick, output lamp_slow, output lamp_fast);
  modport src_in (output pins_sync);
  modport sink   (input tick, input lamp_slow, input lamp_fast, input pins_sync);
endinterface

// [rtl/pin_synchroniser.sv]
// two-stage synchroniser for the start, reset and gate pins
`timescale 1ns/1ns
module pin_synchroniser (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] pins_in,
  timer_link_if.src_in    lnk
);

  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [2:0] nxt_meta;
  logic [2:0] nxt_sync;

  // the first stage feeds only the second stage
  always_comb begin
    nxt_meta = pins_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign lnk.pins_sync = sync_ff;

endmodule // pin_synchroniser

// [rtl/tick_timebase.sv]
// fixed 10 ms tick and the two lamp flash rates
`timescale 1ns/1ns
`include "timer_core_regs.svh"
module tick_timebase #(
  parameter int unsigned TICK_CYCLES = `TMR_TICK_CYCLES
) (
  input  wire logic    clk_in,
  input  wire logic    rst_n_in,
  timer_link_if.src_tb lnk
);

  logic [17:0] cyc_ff;
  logic [17:0] nxt_cyc;
  logic        tick_ff;
  logic        nxt_tick;
  logic [6:0]  slow_ff;
  logic [6:0]  nxt_slow;
  logic [6:0]  fast_ff;
  logic [6:0]  nxt_fast;
  logic        ls_ff;
  logic        nxt_ls;
  logic        lf_ff;
  logic        nxt_lf;

  // free-running divider; flash counters advance on the tick only
  always_comb begin
    nxt_cyc  = cyc_ff + 18'h00001;
    nxt_tick = 1'b0;
    nxt_slow = slow_ff;
    nxt_fast = fast_ff;
    nxt_ls   = ls_ff;
    nxt_lf   = lf_ff;
    if (cyc_ff >= 18'(TICK_CYCLES - 1)) begin
      nxt_cyc  = 18'h00000;
      nxt_tick = 1'b1;
    end
    if (tick_ff) begin
      nxt_slow = slow_ff + 7'h01;
      nxt_fast = fast_ff + 7'h01;
      if (slow_ff >= `SLOW_HALF_TICKS - 7'h01) begin
        nxt_slow = 7'h00;
        nxt_ls   = ~ls_ff;
      end
      if (fast_ff >= `FAST_HALF_TICKS - 7'h01) begin
        nxt_fast = 7'h00;
        nxt_lf   = ~lf_ff;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cyc_ff  <= 18'h00000;
      tick_ff <= 1'b0;
      slow_ff <= 7'h00;
      fast_ff <= 7'h00;
      ls_ff   <= 1'b0;
      lf_ff   <= 1'b0;
    end else begin
      cyc_ff  <= nxt_cyc;
      tick_ff <= nxt_tick;
      slow_ff <= nxt_slow;
      fast_ff <= nxt_fast;
      ls_ff   <= nxt_ls;
      lf_ff   <= nxt_lf;
    end
  end

  assign lnk.tick      = tick_ff;
  assign lnk.lamp_slow = ls_ff;
  assign lnk.lamp_fast = lf_ff;

endmodule // tick_timebase

// [rtl/multimode_delay_timer_core.sv]
// timing core of the multimode delay timer with its register port
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "timer_core_regs.svh"
module multimode_delay_timer_core #(
  parameter int unsigned TICK_CYCLES = `TMR_TICK_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_pin_in,
  input  wire logic        reset_pin_in,
  input  wire logic        gate_pin_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             ctrl_no_out,
  output logic             ctrl_nc_out,
  output logic             inst_out,
  output logic             lamp_out,
  output logic             timing_out
);

  // ****************************************************************************
  // helpers
  // ****************************************************************************

  // full scale of the chosen range, doubled on the double variant
  function automatic logic [15:0] full_scale(input logic [1:0] rng, input logic dbl);
    logic [15:0] fs;
    unique case (rng)
      2'h0: fs = `FS_RANGE0;
      2'h1: fs = `FS_RANGE1;
      2'h2: fs = `FS_RANGE2;
      2'h3: fs = `FS_RANGE3;
    endcase
    return dbl ? {fs[14:0], 1'b0} : fs;
  endfunction

  // true once elapsed has reached nine tenths of the target
  function automatic logic near_end(input logic [15:0] el, input logic [15:0] tg);
    return ({4'h0, el} * `NEAR_DEN) >= ({4'h0, tg} * `NEAR_NUM);
  endfunction

  // ****************************************************************************
  // submodules
  // ****************************************************************************

  timer_link_if lnk ();

  pin_synchroniser u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pins_in  ({gate_pin_in, reset_pin_in, start_pin_in}),
    .lnk      (lnk.src_in)
  );

  tick_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .lnk      (lnk.src_tb)
  );

  // ****************************************************************************
  // configuration decode
  // ****************************************************************************

  logic [`CTRL_W-1:0]           ctrl_ff;
  logic [15:0]                  set_ff;
  logic                         pwr_ff;
  logic                         start_prev_ff;
  timer_core_pkg::state_t       st_ff;
  logic [15:0]                  elapsed_ff;
  logic                         out_ff;
  timer_core_pkg::mode_t        mode_raw;
  timer_core_pkg::mode_t        mode_eff;
  timer_core_pkg::variant_t     variant;
  logic                         transistor;
  logic                         start_eff;
  logic                         reset_eff;
  logic                         gate_eff;
  logic                         rise;
  logic                         fall;
  logic [15:0]                  fs;
  logic [15:0]                  target;
  logic                         reached;
  logic                         timing;

  // reduced-pin parts see the supply as a held start; others read pins
  always_comb begin
    mode_raw   = timer_core_pkg::mode_t'(ctrl_ff[`CTRL_MODE]);
    variant    = timer_core_pkg::variant_t'(ctrl_ff[`CTRL_VAR]);
    transistor = ctrl_ff[`CTRL_TRANS];
    mode_eff   = mode_raw;
    start_eff  = lnk.pins_sync[`PIN_START];
    if (variant == timer_core_pkg::VAR_REDUCED) begin
      start_eff = pwr_ff;  // see R13
      if (mode_raw == timer_core_pkg::MODE_C || mode_raw == timer_core_pkg::MODE_D ||
          mode_raw == timer_core_pkg::MODE_G) begin
        mode_eff = timer_core_pkg::MODE_A;  // see R11
      end
    end
    // voltage and reduced parts have no reset or gate terminal
    reset_eff = lnk.pins_sync[`PIN_RESET] && (variant == timer_core_pkg::VAR_FULL ||
                variant == timer_core_pkg::VAR_SPARE);  // see R12
    gate_eff  = lnk.pins_sync[`PIN_GATE] && (variant == timer_core_pkg::VAR_FULL ||
                variant == timer_core_pkg::VAR_SPARE);  // see R12
    rise      = start_eff && !start_prev_ff;
    fall      = !start_eff && start_prev_ff;
    fs        = full_scale(ctrl_ff[`CTRL_RANGE], ctrl_ff[`CTRL_DOUBLE]);  // see R15
    // a dial turned below zero means zero time; above full scale clamps
    target    = set_ff[15] ? 16'h0000 : ((set_ff > fs) ? fs : set_ff);  // see R09
    reached = elapsed_ff >= target;  // see R16
    timing  = st_ff == timer_core_pkg::ST_ON_DLY || st_ff == timer_core_pkg::ST_OFF_DLY;
  end

  // ****************************************************************************
  // timing sequencer
  // ****************************************************************************

  timer_core_pkg::state_t nxt_st;
  logic [15:0]            nxt_elapsed;
  logic                   nxt_out;
  logic                   nxt_pwr;
  logic                   nxt_prev;

  // reset is checked last so it overrides any start in the same cycle
  always_comb begin
    nxt_st      = st_ff;
    nxt_elapsed = elapsed_ff;
    nxt_out     = out_ff;
    nxt_pwr     = 1'b1;
    nxt_prev    = start_eff;
    if (timing) begin
      // gate freezes the sum; it resumes from the held count
      if (lnk.tick && !gate_eff && !reached) begin
        nxt_elapsed = elapsed_ff + 16'h0001;  // see R03, R04
      end
      if (reached) begin
        unique case (mode_eff)
          timer_core_pkg::MODE_B, timer_core_pkg::MODE_B2: begin
            nxt_out     = ~out_ff;
            nxt_elapsed = 16'h0000;  // flicker restarts; other modes keep the total
          end
          timer_core_pkg::MODE_A, timer_core_pkg::MODE_C, timer_core_pkg::MODE_D,
          timer_core_pkg::MODE_E, timer_core_pkg::MODE_G, timer_core_pkg::MODE_J: begin
            if (st_ff == timer_core_pkg::ST_ON_DLY) begin
              nxt_out = 1'b1;  // see R01
              nxt_st  = timer_core_pkg::ST_HOLD;
            end else begin
              nxt_out = 1'b0;
              nxt_st  = timer_core_pkg::ST_IDLE;
            end
          end
        endcase
      end
    end
    // start release drives the off-delay modes; C gives up if the output never came on
    if (fall && st_ff != timer_core_pkg::ST_IDLE && (mode_eff == timer_core_pkg::MODE_C ||
        mode_eff == timer_core_pkg::MODE_D || mode_eff == timer_core_pkg::MODE_G)) begin
      nxt_elapsed = 16'h0000;
      nxt_st      = (mode_eff != timer_core_pkg::MODE_C || out_ff) ?
                    timer_core_pkg::ST_OFF_DLY : timer_core_pkg::ST_IDLE;
    end
    // only an edge starts, so a held start cannot retrigger a one-shot
    if (rise) begin
      nxt_elapsed = 16'h0000;  // see R05
      nxt_out     = 1'b1;
      unique case (mode_eff)
        timer_core_pkg::MODE_A, timer_core_pkg::MODE_B, timer_core_pkg::MODE_C,
        timer_core_pkg::MODE_G: begin
          nxt_st  = timer_core_pkg::ST_ON_DLY;
          nxt_out = 1'b0;
        end
        timer_core_pkg::MODE_B2: nxt_st = timer_core_pkg::ST_ON_DLY;
        timer_core_pkg::MODE_D:  nxt_st = timer_core_pkg::ST_HOLD;
        timer_core_pkg::MODE_E,
        timer_core_pkg::MODE_J:  nxt_st = timer_core_pkg::ST_OFF_DLY;  // see R08
      endcase
    end
    if (reset_eff) begin
      nxt_st      = timer_core_pkg::ST_IDLE;  // see R02, R05
      nxt_elapsed = 16'h0000;
      nxt_out     = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff         <= timer_core_pkg::ST_IDLE;
      elapsed_ff    <= 16'h0000;
      out_ff        <= 1'b0;
      pwr_ff        <= 1'b0;
      start_prev_ff <= 1'b0;
    end else begin
      st_ff         <= nxt_st;
      elapsed_ff    <= nxt_elapsed;
      out_ff        <= nxt_out;
      pwr_ff        <= nxt_pwr;
      start_prev_ff <= nxt_prev;
    end
  end

  // ****************************************************************************
  // output pins
  // ****************************************************************************

  logic nc_ff;
  logic inst_ff;
  logic lamp_ff;
  logic timing_ff;
  logic nxt_nc;
  logic nxt_inst;
  logic nxt_lamp;

  // transistor parts have no break or instantaneous contact
  always_comb begin
    nxt_nc   = !transistor && !nxt_out;  // see R14
    nxt_inst = !transistor && start_eff && !reset_eff;  // see R14
    if (timing) begin
      nxt_lamp = near_end(elapsed_ff, target) ? lnk.lamp_fast : lnk.lamp_slow;  // see R10
    end else begin
      nxt_lamp = out_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nc_ff     <= 1'b0;
      inst_ff   <= 1'b0;
      lamp_ff   <= 1'b0;
      timing_ff <= 1'b0;
    end else begin
      nc_ff     <= nxt_nc;
      inst_ff   <= nxt_inst;
      lamp_ff   <= nxt_lamp;
      timing_ff <= timing;
    end
  end

  assign ctrl_no_out = out_ff;
  assign ctrl_nc_out = nc_ff;
  assign inst_out    = inst_ff;
  assign lamp_out    = lamp_ff;
  assign timing_out  = timing_ff;

  // ****************************************************************************
  // register port
  // ****************************************************************************

  logic [`CTRL_W-1:0] nxt_ctrl;
  logic [15:0]        nxt_set;
  logic [31:0]        rdata_ff;
  logic [31:0]        nxt_rdata;

  // read data stands only in the cycle after the strobe; holes read zero
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_set   = set_ff;
    nxt_rdata = 32'h00000000;
    if (wr_in && addr_in == `TMR_ADDR_CTRL) begin
      nxt_ctrl = wdata_in[`CTRL_W-1:0];
    end
    if (wr_in && addr_in == `TMR_ADDR_SET) begin
      nxt_set = wdata_in[15:0];
    end
    if (rd_in) begin
      unique case (addr_in)
        `TMR_ADDR_CTRL:    nxt_rdata = {23'h000000, ctrl_ff};
        `TMR_ADDR_SET:     nxt_rdata = {16'h0000, set_ff};
        `TMR_ADDR_STATUS:  nxt_rdata = {25'h0000000, st_ff, lamp_ff,
                                        near_end(elapsed_ff, target), gate_eff,
                                        timing, out_ff};
        `TMR_ADDR_ELAPSED: nxt_rdata = {target, elapsed_ff};
        default:           nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_ff  <= `CTRL_RESET;
      set_ff   <= `SET_RESET;
      rdata_ff <= 32'h00000000;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      set_ff   <= nxt_set;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;

  // ****************************************************************************
  // assertions
  // ****************************************************************************

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_reset_clears: assert property (reset_eff |=> // see R02
    elapsed_ff == 16'h0000 && !out_ff && st_ff == timer_core_pkg::ST_IDLE)
    else $error("reset input did not clear timing");
  a_gate_holds: assert property (timing && gate_eff && !reached && !rise && // see R03
    !fall && !reset_eff |=> elapsed_ff == $past(elapsed_ff))
    else $error("elapsed moved while gated");
  a_sum_steps: assert property ($changed(elapsed_ff) |-> // see R04
    elapsed_ff == 16'h0000 || (elapsed_ff == $past(elapsed_ff) + 16'h0001 &&
    $past(lnk.tick)))
    else $error("elapsed changed other than by one tick");
  a_start_in_gate: assert property (gate_eff && rise && !reset_eff |=> // see R05
    st_ff != timer_core_pkg::ST_IDLE && elapsed_ff == 16'h0000)
    else $error("start ignored under gate");
  a_reached_on: assert property (mode_eff == timer_core_pkg::MODE_A && reached && // see R01
    st_ff == timer_core_pkg::ST_ON_DLY && !rise && !reset_eff |=> out_ff ##1 out_ff)
    else $error("on-delay output not switched");
  a_zero_set: assert property (set_ff[15] && rise && !reset_eff && // see R09
    mode_eff == timer_core_pkg::MODE_A |-> ##[2:3] out_ff)
    else $error("negative set value did not switch at once");
  a_oneshot_once: assert property (mode_eff == timer_core_pkg::MODE_J && // see R08
    st_ff == timer_core_pkg::ST_IDLE && !rise |=> !out_ff)
    else $error("one-shot pulsed without a new start");
  a_lamp_near: assert property (timing && near_end(elapsed_ff, target) && // see R10
    !$changed(lnk.lamp_fast) |=> lamp_out == $past(lnk.lamp_fast))
    else $error("lamp not at fast rate near the end");
  a_trans_no_nc: assert property (transistor && $past(transistor) |-> // see R14
    !ctrl_nc_out && !inst_out)
    else $error("transistor variant drove a break or instant output");
  a_volt_no_gate: assert property (variant == timer_core_pkg::VAR_VOLT && timing && // see R12
    lnk.tick && !reached && !rise && !fall |=> elapsed_ff == $past(elapsed_ff) + 16'h0001)
    else $error("voltage variant honoured gate or reset");
  a_power_start: assert property (variant == timer_core_pkg::VAR_REDUCED && // see R13
    pwr_ff && !start_prev_ff |=> st_ff != timer_core_pkg::ST_IDLE)
    else $error("reduced variant missed power-up start");
endmodule // multimode_delay_timer_core

// [verif/pin_source_model.sv]
// far-side model: contacts that drive the start, reset and gate pins
`timescale 1ns/1ns
module pin_source_model #(
  parameter int unsigned MIN_HOLD = 20
) (
  input  wire logic clk_in,
  output logic      start_out,
  output logic      reset_out,
  output logic      gate_out
);
  // contacts rest open
  initial begin
    start_out = 1'b0;
    reset_out = 1'b0;
    gate_out  = 1'b0;
  end

  // a pulse never shorter than the minimum width, since the core may miss it
  task automatic pulse(input int unsigned which, input int unsigned len);
    int unsigned n;
    n = (len < MIN_HOLD) ? MIN_HOLD : len;
    @(posedge clk_in);
    if (which == 0) start_out <= 1'b1;
    else reset_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    if (which == 0) start_out <= 1'b0;
    else reset_out <= 1'b0;
  endtask

  // gate is a level held as long as the caller wants
  task automatic set_gate(input logic lvl);
    @(posedge clk_in);
    gate_out <= lvl;
  endtask
endmodule // pin_source_model

// [verif/multimode_delay_timer_core_bench.sv]
// self-checking bench of the delay timer core
`timescale 1ns/1ns
module multimode_delay_timer_core_bench;
  localparam int unsigned TICK = 4;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  addr_in  = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic [31:0] rdata_out;
  logic        start_p, reset_p, gate_p, no_w, nc_w, inst_w, lamp_w, timing_w;
  logic [31:0] rv;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          rises      = 0;
  int          fs [4]     = '{120, 300, 1200, 3000};

  always #20 clk_in = ~clk_in;

  pin_source_model #(.MIN_HOLD(5 * TICK)) src_u (.clk_in(clk_in), .start_out(start_p),
    .reset_out(reset_p), .gate_out(gate_p));

  multimode_delay_timer_core #(.TICK_CYCLES(TICK)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .start_pin_in(start_p), .reset_pin_in(reset_p), .gate_pin_in(gate_p), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ctrl_no_out(no_w), .ctrl_nc_out(nc_w), .inst_out(inst_w), .lamp_out(lamp_w),
    .timing_out(timing_w));

  // hang guard; the limit is far above the well under two thousand cycles the tests take
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // output pulses, to tell one pulse from a retrigger
  always @(posedge no_w) rises++;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  // register port: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // bounded wait for the time-limit output to reach a level
  task automatic wait_no(input logic lvl, output int n);
    n = 0;
    while (no_w !== lvl && n < 400) begin
      @(posedge clk_in);
      #1 n++;
    end
  endtask

  // model of the effective target: negative is zero, above full scale clamps
  function automatic int tgt(input int s, input int r, input int d);
    int f;
    f = fs[r] * (d + 1);
    return (s < 0) ? 0 : ((s > f) ? f : s);
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int n;
    int s;
    int c0;
    logic [31:0] e1;
    void'($urandom(32'hF02E56B4));
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // set register reset value, unmapped place, every mode code
    rd(4'h4, rv);
    check_word(rv, 32'h0);
    rd(4'h2, rv);
    check_word(rv, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(4'h0, 32'(m));
      rd(4'h0, rv);
      check_word(rv, 32'(m));
    end
    // every range, plain and doubled, clamped and random in-scale
    for (int r = 0; r < 8; r++) begin
      s = $urandom_range(119, 1);
      wr(4'h0, 32'(r << 3));
      wr(4'h4, 32'h7FFF);
      rd(4'hC, rv);
      check_word(rv >> 16, 32'(tgt(32767, r % 4, r / 4)));
      wr(4'h4, 32'(s));
      rd(4'hC, rv);
      check_word(rv >> 16, 32'(tgt(s, r % 4, r / 4)));
    end
    // on-delay: off while timing, on after set count of ticks
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h000A);
    c0 = cyc;
    src_u.pulse(0, 20);
    check_bit(no_w, 1'b0);
    check_bit(timing_w, 1'b1);
    check_bit(inst_w & nc_w, 1'b1);
    wait_no(1'b1, n);
    check_bit(cyc - c0 >= 36 && cyc - c0 <= 48, 1'b1);
    rd(4'hC, rv);
    check_word(rv, 32'h000A_000A);
    rd(4'h8, rv);
    check_word(rv & 32'h7F, 32'h79);
    check_bit(lamp_w, 1'b1);
    // gate splits timing; intervals add up
    s = 16 + $urandom_range(15, 0);
    wr(4'h4, 32'(s));
    src_u.pulse(1, 20);
    check_bit(no_w, 1'b0);
    src_u.pulse(0, 20);
    src_u.set_gate(1'b1);
    repeat (8) @(posedge clk_in);
    rd(4'hC, e1);
    repeat (20) @(posedge clk_in);
    rd(4'hC, rv);
    check_word(rv, e1);
    rd(4'h8, rv);
    check_bit(rv[3], 1'(int'(e1[15:0]) * 10 >= s * 9));
    src_u.set_gate(1'b0);
    wait_no(1'b1, n);
    rd(4'hC, rv);
    check_word(rv & 32'hFFFF, 32'(s));
    // reset and start still act under the gate
    src_u.set_gate(1'b1);
    src_u.pulse(1, 20);
    check_bit(no_w, 1'b0);
    rd(4'hC, rv);
    check_word(rv & 32'hFFFF, 32'h0);
    src_u.pulse(0, 20);
    check_bit(timing_w, 1'b1);
    src_u.set_gate(1'b0);
    src_u.pulse(1, 20);
    check_bit(timing_w, 1'b0);
    // one-shot with start held past the set time
    wr(4'h0, 32'h7);
    wr(4'h4, 32'h5);
    rises = 0;
    src_u.pulse(0, 80);
    repeat (10) @(posedge clk_in);
    check_word(32'(rises), 32'h1);
    check_bit(no_w, 1'b0);
    // flicker: the output toggles every set time while timing
    wr(4'h0, 32'h1);
    src_u.pulse(0, 20);
    wait_no(1'b1, n);
    wait_no(1'b0, n);
    check_bit(n >= 16 && n <= 24, 1'b1);
    // negative set value switches at once
    wr(4'h0, 32'h0);
    wr(4'h4, 32'hFFF6);
    src_u.pulse(1, 20);
    fork
      src_u.pulse(0, 20);
      wait_no(1'b1, n);
    join
    check_bit(n <= 6, 1'b1);
    rd(4'hC, rv);
    check_word(rv >> 16, 32'h0);
    // transistor variant: no break or instantaneous contact
    src_u.pulse(1, 20);
    wr(4'h0, 32'h100);
    wr(4'h4, 32'h000A);
    src_u.pulse(0, 20);
    check_bit(inst_w | nc_w, 1'b0);
    wait_no(1'b1, n);
    check_bit(nc_w, 1'b0);
    // voltage-input variant ignores the reset pin
    src_u.pulse(1, 20);
    wr(4'h0, 32'h40);
    src_u.pulse(0, 20);
    src_u.pulse(1, 20);
    wait_no(1'b1, n);
    check_bit(no_w, 1'b1);
    // power-off reset long enough, then power start on the reduced variant
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (10 * TICK) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(4'hC, rv);
    check_word(rv, 32'h0);
    wr(4'h4, 32'h3);
    wr(4'h0, 32'h80);
    wait_no(1'b1, n);
    check_bit(no_w, 1'b1);
    end_sim();
  end
endmodule // multimode_delay_timer_core_bench
